//--- logic/smio_regs.vh
// register map, field positions, reset values and timing counts
`ifndef SMIO_REGS_VH
`define SMIO_REGS_VH

// byte offsets on the apb bus
`define SMIO_OFS_MODE_LOW   12'h000
`define SMIO_OFS_MODE_HIGH  12'h004
`define SMIO_OFS_TX_BUF     12'h008
`define SMIO_OFS_RX_BUF     12'h00C
`define SMIO_OFS_IRQ_STAT   12'h010
`define SMIO_OFS_IRQ_MASK   12'h014
`define SMIO_OFS_STATE      12'h018

// reset values (the mode ones also hardware stop values), and the io mode pattern of serial mode low
`define SMIO_MODE_LOW_RST   8'h48
`define SMIO_MODE_HIGH_RST  8'h00
`define SMIO_MODE_LOW_IO    8'h0C
`define SMIO_MASK_RST       3'h0

// serial mode low fields
`define SMIO_ML_RATE_LO     0
`define SMIO_ML_RATE_HI     1
`define SMIO_ML_LEN_LO      2
`define SMIO_ML_LEN_HI      3
`define SMIO_ML_PEN         4
`define SMIO_ML_EVEN        5
`define SMIO_ML_STOP_LO     6
`define SMIO_ML_STOP_HI     7
`define SMIO_RATE_X1        2'h1

// serial mode high fields
`define SMIO_MH_SK_LO       0
`define SMIO_MH_SK_HI       1
`define SMIO_MH_TXE         2
`define SMIO_MH_RXE         3
`define SMIO_MH_SE          4
`define SMIO_MH_IOE         5
`define SMIO_MH_TSK         6

// clock source codes
`define SMIO_SK_TIMER       2'h0
`define SMIO_SK_DIV384      2'h1
`define SMIO_SK_DIV24       2'h2
`define SMIO_SK_EXT         2'h3

// interrupt status and mask bits
`define SMIO_IRQ_TX_EMPTY   0
`define SMIO_IRQ_RX_FULL    1
`define SMIO_IRQ_CFG_ERR    2

// divider ratios and high hold after the eighth clock
`define SMIO_DIV_A          24
`define SMIO_DIV_B          384
`define SMIO_HOLD_STATES    6
`define SMIO_CYC_PER_STATE  1

`endif

//--- logic/smio_sync.v
`timescale 1ns/1ps
`default_nettype none
module smio_sync #(
  parameter W = 4
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta_reg;   // first stage, read only by dout

  // two flip-flop synchroniser, inputs idle high
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= {W{1'b1}};
      dout     <= {W{1'b1}};
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule
`default_nettype wire

//--- logic/smio_clkdiv.v
`timescale 1ns/1ps
`default_nettype none
`include "smio_regs.vh"
module smio_clkdiv (
  input  wire pclk,
  input  wire presetn,
  output reg  tick_a,
  output reg  tick_b
);

  // half periods, so two ticks make one serial clock period
  localparam integer HALF_A_I = `SMIO_DIV_A / 2;
  localparam integer HALF_B_I = `SMIO_DIV_B / 2;
  // both halves fit eight bits, so the cut drops only zeros
  localparam [7:0] HALF_A = HALF_A_I[7:0];
  localparam [7:0] HALF_B = HALF_B_I[7:0];

  reg [7:0] cnt_a_reg;    // fast divider count
  reg [7:0] cnt_b_reg;    // slow divider count

  // free running dividers, a tick each half period
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_a_reg <= 8'h00;
      cnt_b_reg <= 8'h00;
      tick_a    <= 1'b0;
      tick_b    <= 1'b0;
    end
    else
    begin
      tick_a <= (cnt_a_reg == HALF_A - 8'h01);
      tick_b <= (cnt_b_reg == HALF_B - 8'h01);
      if (cnt_a_reg == HALF_A - 8'h01)
        cnt_a_reg <= 8'h00;
      else
        cnt_a_reg <= cnt_a_reg + 8'h01;
      if (cnt_b_reg == HALF_B - 8'h01)
        cnt_b_reg <= 8'h00;
      else
        cnt_b_reg <= cnt_b_reg + 8'h01;
    end
  end

endmodule
`default_nettype wire

//--- logic/smio_top.v
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "smio_regs.vh"
module smio_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        serial_in_pin,
  output reg         serial_out_pin,
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe_n,
  input  wire        timer_output,
  input  wire        timer_direct,
  input  wire        hw_stop_pin,
  output reg         irq
);

  // generator states, one hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN  = 3'h2;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam integer HOLD_I = `SMIO_HOLD_STATES * `SMIO_CYC_PER_STATE;
  localparam [3:0] HOLD_CYC = HOLD_I[3:0];

  reg  [7:0] mode_low_reg;     // serial_mode_low
  reg  [7:0] mode_high_reg;    // serial_mode_high
  reg  [7:0] tx_buf_reg;       // transmit_buffer
  reg        tx_full_reg;      // transmit buffer holds a byte
  reg  [7:0] tx_shift_reg;     // outgoing shifter
  reg        tx_busy_reg;      // shifter holds unsent bits
  reg  [2:0] tx_cnt_reg;       // transmit bit counter
  reg  [7:0] rx_shift_reg;     // incoming shifter
  reg  [7:0] rx_buf_reg;       // receive buffer
  reg  [2:0] rx_cnt_reg;       // receive bit counter
  reg  [2:0] irq_stat_reg;     // sticky events
  reg  [2:0] irq_mask_reg;     // 1 lets an event reach irq
  reg  [2:0] gen_state_reg;    // internal clock generator
  reg  [3:0] gen_cnt_reg;      // rising edges, then hold cycles
  reg        sck_int_reg;      // internally made clock level
  reg        ext_prev_reg;     // last synchronised external clock
  reg        tmr_prev_reg;     // last synchronised timer output

  wire [3:0] pins_s;           // synchronised pins
  wire       rx_s;
  wire       sck_s;
  wire       tmr_s;
  wire       stop_s;
  wire       tick_a;
  wire       tick_b;

  // every pin from outside except timer_direct and the apb bus passes two flip-flops
  smio_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({hw_stop_pin, timer_output, sck_in, serial_in_pin}),
    .dout    (pins_s)
  );
  assign rx_s   = pins_s[0];
  assign sck_s  = pins_s[1];
  assign tmr_s  = pins_s[2];
  assign stop_s = pins_s[3];

  smio_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_a  (tick_a),
    .tick_b  (tick_b)
  );

  // field decode
  wire [1:0] clk_src   = mode_high_reg[`SMIO_MH_SK_HI:`SMIO_MH_SK_LO];
  wire       tx_en     = mode_high_reg[`SMIO_MH_TXE];
  wire       rx_en     = mode_high_reg[`SMIO_MH_RXE];
  wire       search_en = mode_high_reg[`SMIO_MH_SE];
  wire       io_en     = mode_high_reg[`SMIO_MH_IOE];
  wire       start_trg = mode_high_reg[`SMIO_MH_TSK];
  wire [1:0] rate_sel  = mode_low_reg[`SMIO_ML_RATE_HI:`SMIO_ML_RATE_LO];
  wire       ext_clk   = (clk_src == `SMIO_SK_EXT);
  wire       io_mode   = io_en && (mode_low_reg == `SMIO_MODE_LOW_IO);

  // clock source picks what paces the generator: timer output edges or a divider tick
  reg gen_tick;
  always @*
  begin
    case (clk_src)
      `SMIO_SK_DIV24:  gen_tick = tick_a;
      `SMIO_SK_DIV384: gen_tick = tick_b;
      `SMIO_SK_TIMER:  gen_tick = (tmr_s != tmr_prev_reg);
      default:         gen_tick = 1'b0;
    endcase
  end

  // shared clock edges, internal or external
  wire gen_run  = (gen_state_reg == ST_RUN);
  wire int_fall = gen_run && gen_tick && sck_int_reg;
  wire int_rise = gen_run && gen_tick && !sck_int_reg;
  wire sck_fall = ext_clk ? (ext_prev_reg && !sck_s) : int_fall;
  wire sck_rise = ext_clk ? (!ext_prev_reg && sck_s) : int_rise;

  // apb decode, write or read lands at the completing edge
  wire apb_done = psel && penable && pready;
  wire apb_wr   = apb_done && pwrite;
  wire apb_rd   = apb_done && !pwrite;
  wire wr_low   = apb_wr && (paddr == `SMIO_OFS_MODE_LOW);
  wire wr_high  = apb_wr && (paddr == `SMIO_OFS_MODE_HIGH);
  wire wr_tx    = apb_wr && (paddr == `SMIO_OFS_TX_BUF);
  wire wr_mask  = apb_wr && (paddr == `SMIO_OFS_IRQ_MASK);
  wire rd_stat  = apb_rd && (paddr == `SMIO_OFS_IRQ_STAT);

  // loads happen only with transmit enabled
  // full duplex on the shared clock, one character at a time
  wire tx_load  = tx_en && tx_full_reg && !tx_busy_reg &&
                  (ext_clk || gen_state_reg == ST_IDLE);
  // trigger only with internal clock in io mode
  wire rx_start = io_mode && rx_en && start_trg && !ext_clk &&
                  (gen_state_reg == ST_IDLE) && !tx_load;
  wire gen_go   = !ext_clk && (gen_state_reg == ST_IDLE) &&
                  (tx_load || rx_start);

  // events for the sticky status
  wire rx_word  = rx_en && sck_rise &&
                  ((rx_cnt_reg == 3'h7) || (search_en && !io_en));
  // x1 rate with direct fed timer is flagged as a configuration error
  wire cfg_err  = (clk_src == `SMIO_SK_TIMER) && timer_direct &&
                  !io_en && (rate_sel == `SMIO_RATE_X1);
  wire [2:0] ev = {cfg_err, rx_word, tx_load};

  // bit order: msb first in io mode, lsb first otherwise
  function [7:0] smio_shift;
    input [7:0] d;
    input       msb_first;
    input       b;
    begin
      smio_shift = msb_first ? {d[6:0], b} : {b, d[7:1]};
    end
  endfunction

  // apb register reads, unmapped address flags an error
  reg [31:0] rd_mux;
  reg        rd_bad;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_bad = 1'b0;
    case (paddr)
      `SMIO_OFS_MODE_LOW:  rd_mux = {24'h000000, mode_low_reg};
      `SMIO_OFS_MODE_HIGH: rd_mux = {24'h000000, mode_high_reg};
      `SMIO_OFS_TX_BUF:    rd_mux = {24'h000000, tx_buf_reg};
      `SMIO_OFS_RX_BUF:    rd_mux = {24'h000000, rx_buf_reg};
      `SMIO_OFS_IRQ_STAT:  rd_mux = {29'h00000000, irq_stat_reg};
      `SMIO_OFS_IRQ_MASK:  rd_mux = {29'h00000000, irq_mask_reg};
      `SMIO_OFS_STATE:     rd_mux = {29'h00000000, gen_run,
                                     tx_busy_reg, tx_full_reg};
      default:             rd_bad = 1'b1;
    endcase
  end

  // apb handshake, one wait state so outputs come from flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      pslverr <= rd_bad;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // mode registers, reset and hardware stop share defaults
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_low_reg  <= `SMIO_MODE_LOW_RST;
      mode_high_reg <= `SMIO_MODE_HIGH_RST;
    end
    else if (stop_s)
    begin
      mode_low_reg  <= `SMIO_MODE_LOW_RST;
      mode_high_reg <= `SMIO_MODE_HIGH_RST;
    end
    else
    begin
      if (wr_low)
        mode_low_reg <= pwdata[7:0];
      if (wr_high)
        mode_high_reg <= pwdata[7:0];
      // trigger self clears as clock starts
      else if (rx_start)
        mode_high_reg[`SMIO_MH_TSK] <= 1'b0;
    end
  end

  // transmit path
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buf_reg     <= 8'h00;
      tx_full_reg    <= 1'b0;
      tx_shift_reg   <= 8'h00;
      tx_busy_reg    <= 1'b0;
      tx_cnt_reg     <= 3'h0;
      serial_out_pin <= 1'b1;
    end
    else
    begin
      // a write during the load cycle refills the buffer
      if (wr_tx)
      begin
        tx_buf_reg  <= pwdata[7:0];
        tx_full_reg <= 1'b1;
      end
      else if (tx_load)
        tx_full_reg <= 1'b0;
      if (tx_load)
      begin
        tx_shift_reg <= tx_buf_reg;
        tx_busy_reg  <= 1'b1;
        tx_cnt_reg   <= 3'h0;
      end
      else if (tx_busy_reg && sck_fall)
      begin
        // next bit leaves on the falling edge
        serial_out_pin <= io_mode ? tx_shift_reg[7] : tx_shift_reg[0];
        tx_shift_reg   <= smio_shift(tx_shift_reg, io_mode, 1'b1);
      end
      else if (tx_busy_reg && sck_rise)
      begin
        tx_cnt_reg <= tx_cnt_reg + 3'h1;
        if (tx_cnt_reg == 3'h7)
          tx_busy_reg <= 1'b0;
      end
      // mark level when idle or disabled
      // waits for the clock pin to rise, so the last bit outlives it
      if (!tx_en || (!tx_busy_reg && !tx_load && sck_out))
        serial_out_pin <= 1'b1;
    end
  end

  // receive path
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_shift_reg <= 8'h00;
      rx_buf_reg   <= 8'h00;
      rx_cnt_reg   <= 3'h0;
    end
    else if (!rx_en)
      rx_cnt_reg <= 3'h0;
    else if (sck_rise)
    begin
      // sample the input on the rising edge
      rx_shift_reg <= smio_shift(rx_shift_reg, io_mode, rx_s);
      rx_cnt_reg   <= rx_cnt_reg + 3'h1;
      // full character moves to the buffer
      if (rx_word)
        rx_buf_reg <= smio_shift(rx_shift_reg, io_mode, rx_s);
    end
  end

  // internal clock generator: eight periods, then a high hold
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gen_state_reg <= ST_IDLE;
      gen_cnt_reg   <= 4'h0;
      sck_int_reg   <= 1'b1;
    end
    else
    begin
      case (gen_state_reg)
        ST_IDLE:
        begin
          sck_int_reg <= 1'b1;
          gen_cnt_reg <= 4'h0;
          if (gen_go)
            gen_state_reg <= ST_RUN;
        end
        ST_RUN:
        begin
          if (ext_clk)
            gen_state_reg <= ST_IDLE;
          else if (gen_tick)
          begin
            sck_int_reg <= !sck_int_reg;
            // eighth rising edge ends the character
            if (!sck_int_reg)
            begin
              if (gen_cnt_reg == 4'h7)
              begin
                gen_cnt_reg   <= 4'h0;
                gen_state_reg <= ST_HOLD;
              end
              else
                gen_cnt_reg <= gen_cnt_reg + 4'h1;
            end
          end
        end
        ST_HOLD:
        begin
          sck_int_reg <= 1'b1;
          if (gen_cnt_reg >= HOLD_CYC - 4'h1)
            gen_state_reg <= ST_IDLE;
          else
            gen_cnt_reg <= gen_cnt_reg + 4'h1;
        end
        default:
          gen_state_reg <= ST_IDLE;
      endcase
    end
  end

  // clock pin drive and edge history
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_out      <= 1'b1;
      sck_oe_n     <= 1'b1;
      ext_prev_reg <= 1'b1;
      tmr_prev_reg <= 1'b1;
    end
    else
    begin
      // clock rests high outside a character
      sck_out      <= sck_int_reg;
      sck_oe_n     <= ext_clk;
      ext_prev_reg <= sck_s;
      tmr_prev_reg <= tmr_s;
    end
  end

  // sticky status: read clears only the bits it reported, events win
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= `SMIO_MASK_RST;
      irq          <= 1'b0;
    end
    else
    begin
      // transmit buffer empty sets its bit
      // receive buffer full sets its bit
      irq_stat_reg <= (irq_stat_reg & ~(rd_stat ? prdata[2:0] : 3'h0)) | ev;
      if (wr_mask)
        irq_mask_reg <= pwdata[2:0];
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule
`default_nettype wire

//--- bench/smio_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module smio_top_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_out_pin,
  input wire logic        sck_out
);
  logic [7:0] high_cnt_reg;  // cycles the serial clock has stood high

  // saturating count of the high phase, long rests mean no frame
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_cnt_reg <= 8'h00;
    else if (!sck_out)
      high_cnt_reg <= 8'h00;
    else if (high_cnt_reg != 8'hFF)
      high_cnt_reg <= high_cnt_reg + 8'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access_start;
    psel && $rose(penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  a_one_wait: assert property (s_access_start |-> s_one_wait)
    else $error("apb answer not after exactly one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_nodata: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_err: assert property
    (psel && penable && pready && paddr > 12'h018 |-> pslverr)
    else $error("unmapped address accepted");
  a_mapped_ok: assert property (psel && penable && pready
    && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  a_low_width: assert property (
    $fell(sck_out) |-> (!sck_out)[*8])
    else $error("serial clock low phase too short");
  a_high_hold: assert property (
    $rose(sck_out) |-> sck_out[*6])
    else $error("serial clock high phase under six states");
  a_idle_mark: assert property (
    high_cnt_reg == 8'hC8 |-> serial_out_pin)
    else $error("data line not marking while idle");
endmodule

bind smio_top smio_top_props u_props (
  .pclk           (pclk),
  .presetn        (presetn),
  .psel           (psel),
  .penable        (penable),
  .paddr          (paddr),
  .prdata         (prdata),
  .pready         (pready),
  .pslverr        (pslverr),
  .serial_out_pin (serial_out_pin),
  .sck_out        (sck_out)
);
`default_nettype wire

//--- bench/smio_peer.sv
`timescale 1ns/1ps
`default_nettype none
module smio_peer (
  input wire logic       pclk,
  input wire logic       rst_n,
  input wire logic       sck,
  input wire logic       sdo,
  input wire logic [7:0] tx_byte,
  output logic           sdi,
  output logic [7:0]     rx_byte,
  output int             rises
);
  logic [2:0] fall_idx;  // bit being sent
  logic [2:0] rise_idx;  // bit being taken
  logic [3:0] quiet;     // cycles of high clock

  initial
  begin
    sdi = 1'b1;
    rx_byte = 8'h00;
    rises = 0;
    fall_idx = 3'h0;
    rise_idx = 3'h0;
    quiet = 4'h0;
  end

  // clock left to device
  // the peer never drives the clock, so rate and high hold are not its part
  // take one bit on each rising clock, msb first
  always @(posedge sck)
  begin
    if (rst_n)
    begin
      rx_byte <= {rx_byte[6:0], sdo};
      rise_idx <= rise_idx + 3'h1;
      rises <= rises + 1;
    end
  end

  always @(negedge sck)
  begin
    if (rst_n)
    begin
      sdi <= tx_byte[3'h7 - fall_idx];
      fall_idx <= fall_idx + 3'h1;
    end
  end

  // after the hold the released line wanders, so stale data cannot pass
  always @(posedge pclk)
  begin
    if (!sck)
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
    if (rise_idx == 3'h0 && fall_idx == 3'h0 && quiet >= 4'h6)
      sdi <= ~sdi;
  end
endmodule
`default_nettype wire

//--- bench/tb_serial_interface_io_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "smio_regs.vh"
module tb_serial_interface_io_mode_control;
  localparam int LIMIT = 20000;  // far above the several hundred cycles used
  logic        pclk, presetn, psel, penable, pwrite, sck_in;
  logic        timer_output, timer_direct, hw_stop_pin, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  wire  [31:0] prdata;
  wire         pready, pslverr, serial_in_pin, serial_out_pin;
  wire         sck_out, sck_oe_n, irq;
  logic [7:0]  peer_tx;
  wire  [7:0]  peer_rx;
  int          peer_rises, fails, cmp_count, cyc, r0;

  smio_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .timer_output(timer_output), .timer_direct(timer_direct),
    .hw_stop_pin(hw_stop_pin), .irq(irq));
  smio_peer peer (.pclk(pclk), .rst_n(presetn), .sck(sck_out),
    .sdo(serial_out_pin), .tx_byte(peer_tx), .sdi(serial_in_pin),
    .rx_byte(peer_rx), .rises(peer_rises));

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fails++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll the state register until nothing is pending
  task automatic wait_idle;
    int n;
    n = 0;
    apb(1'b0, `SMIO_OFS_STATE, 32'h0);
    while (rdat[2:0] !== 3'h0 && n < 200)
    begin
      apb(1'b0, `SMIO_OFS_STATE, 32'h0);
      n++;
    end
    if (n == 200)
    begin
      fails++;
      $display("wrong value at %0t: block never went idle", $time);
    end
  endtask

  task automatic t_reset;
    apb(1'b0, `SMIO_OFS_MODE_LOW, 32'h0);
    chk(rdat[7:0], 8'h48);
    apb(1'b0, `SMIO_OFS_MODE_HIGH, 32'h0);
    chk(rdat[7:0], 8'h00);
    apb(1'b1, 12'h01C, 32'h0000_00FF);
    chk({7'h00, rerr}, 8'h01);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rdat[7:0], 8'h00);
    apb(1'b1, `SMIO_OFS_MODE_LOW, 32'h0000_00B7);
    apb(1'b0, `SMIO_OFS_MODE_LOW, 32'h0);
    chk(rdat[7:0], 8'hB7);
  endtask

  // byte waits while sending is off, then leaves once enabled
  task automatic t_tx;
    r0 = peer_rises;
    apb(1'b1, `SMIO_OFS_MODE_LOW, 32'h0000_000C);
    apb(1'b1, `SMIO_OFS_IRQ_MASK, 32'h0000_0003);
    apb(1'b1, `SMIO_OFS_MODE_HIGH, 32'h0000_0022);
    apb(1'b1, `SMIO_OFS_TX_BUF, 32'h0000_003C);
    apb(1'b0, `SMIO_OFS_STATE, 32'h0);
    chk({5'h00, rdat[2:0]}, 8'h01);
    chk({7'h00, sck_oe_n}, 8'h00);
    chk(8'(peer_rises - r0), 8'h00);
    apb(1'b1, `SMIO_OFS_MODE_HIGH, 32'h0000_0026);
    wait_idle();
    chk(peer_rx, 8'h3C);
    chk(8'(peer_rises - r0), 8'h08);
    repeat (2) @(posedge pclk);
    chk({7'h00, serial_out_pin}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    apb(1'b0, `SMIO_OFS_IRQ_STAT, 32'h0);
    chk({7'h00, rdat[0]}, 8'h01);
    repeat (2) @(posedge pclk);
    chk({7'h00, irq}, 8'h00);
  endtask

  // internal clock started by the trigger, receive event masked
  task automatic t_rx;
    peer_tx = 8'h96;
    r0 = peer_rises;
    apb(1'b1, `SMIO_OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, `SMIO_OFS_MODE_HIGH, 32'h0000_006A);
    wait_idle();
    apb(1'b0, `SMIO_OFS_MODE_HIGH, 32'h0);
    chk(rdat[7:0], 8'h2A);
    apb(1'b0, `SMIO_OFS_RX_BUF, 32'h0);
    chk(rdat[7:0], 8'h96);
    chk(8'(peer_rises - r0), 8'h08);
    chk({7'h00, irq}, 8'h00);
    apb(1'b0, `SMIO_OFS_IRQ_STAT, 32'h0);
    chk({7'h00, rdat[1]}, 8'h01);
  endtask

  // fastest timer feed allows only the divided rates
  task automatic t_cfg;
    apb(1'b1, `SMIO_OFS_MODE_HIGH, 32'h0);
    apb(1'b1, `SMIO_OFS_MODE_LOW, 32'h0000_004D);
    timer_direct <= 1'b1;
    apb(1'b0, `SMIO_OFS_IRQ_STAT, 32'h0);
    apb(1'b0, `SMIO_OFS_IRQ_STAT, 32'h0);
    chk({7'h00, rdat[2]}, 8'h01);
    apb(1'b1, `SMIO_OFS_MODE_LOW, 32'h0000_004E);
    apb(1'b0, `SMIO_OFS_IRQ_STAT, 32'h0);
    apb(1'b0, `SMIO_OFS_IRQ_STAT, 32'h0);
    chk({7'h00, rdat[2]}, 8'h00);
    timer_direct <= 1'b0;
  endtask

  // bench drives the clock pin, device releases it and shifts out
  task automatic t_ext;
    logic [7:0] got;
    got = 8'h00;
    apb(1'b1, `SMIO_OFS_MODE_LOW, 32'h0000_000C);
    apb(1'b1, `SMIO_OFS_MODE_HIGH, 32'h0000_0027);
    apb(1'b1, `SMIO_OFS_TX_BUF, 32'h0000_00A5);
    repeat (2) @(posedge pclk);
    chk({7'h00, sck_oe_n}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      sck_in <= 1'b0;
      repeat (8) @(posedge pclk);
      got = {got[6:0], serial_out_pin};
      sck_in <= 1'b1;
      repeat (8) @(posedge pclk);
    end
    chk(got, 8'hA5);
    repeat (2) @(posedge pclk);
    chk({7'h00, serial_out_pin}, 8'h01);
  endtask

  task automatic t_stop;
    apb(1'b1, `SMIO_OFS_MODE_HIGH, 32'h0000_0026);
    hw_stop_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, `SMIO_OFS_MODE_LOW, 32'h0);
    chk(rdat[7:0], 8'h48);
    apb(1'b0, `SMIO_OFS_MODE_HIGH, 32'h0);
    chk(rdat[7:0], 8'h00);
    hw_stop_pin <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, timer_output} = 5'h00;
    {timer_direct, hw_stop_pin, rerr} = 3'h0;
    sck_in = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    rdat = 32'h0;
    peer_tx = 8'h00;
    {fails, cmp_count, cyc, r0} = {4{32'sd0}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_cfg();
    t_ext();
    t_stop();
    print_verdict();
  end
endmodule
`default_nettype wire
